// [pcc_defines.svh]
// Purpose: Shared constants for the card slot host cycle controller
// Assumes: Included by bare name wherever a constant is needed
// Notes: Cycle counts are defaults; the top module exposes all but PCC_SYNC_STAGES as parameters
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PCC_ADDR_W 26
`define PCC_PIN_ADDR_W 13
`define PCC_DATA_W 16
`define PCC_CNT_W 8

// ----------------------------------------------------------------
// Address split on the multiplexed pins
// ----------------------------------------------------------------
`define PCC_ADDR_HI_MSB 25
`define PCC_ADDR_HI_LSB 13
`define PCC_ADDR_LO_MSB 12

// ----------------------------------------------------------------
// Byte lanes
// ----------------------------------------------------------------
`define PCC_LANE_LOW 2'h1
`define PCC_LANE_HIGH 2'h2
`define PCC_LANE_BOTH 2'h3
`define PCC_LANE_NONE 2'h0
`define PCC_BYTE_W 8

// ----------------------------------------------------------------
// Default phase lengths in sys_clk cycles
// ----------------------------------------------------------------
`define PCC_ALE_CYC 2
`define PCC_SETUP_CYC 1
`define PCC_STROBE_CYC 4
`define PCC_RECOVER_CYC 2
`define PCC_SYNC_STAGES 2

`endif

// [pcc_pkg.sv]
// Purpose: Types for the card slot host cycle controller
// Assumes: One-hot state codes
// Notes: Space codes are user-side only, never driven on pins
package pcc_pkg;

  typedef enum logic [1:0] {
    PCC_SPACE_MEM  = 2'h0,
    PCC_SPACE_ATTR = 2'h1,
    PCC_SPACE_IO   = 2'h2
  } pcc_space_type;

  typedef enum logic [6:0] {
    PCC_ST_IDLE    = 7'h01,
    PCC_ST_ADDR_HI = 7'h02,
    PCC_ST_ADDR_LO = 7'h04,
    PCC_ST_ENABLE  = 7'h08,
    PCC_ST_STROBE  = 7'h10,
    PCC_ST_WAIT    = 7'h20,
    PCC_ST_RECOVER = 7'h40
  } pcc_state_type;

endpackage

// [pcc_lane_if.sv]
// Purpose: Carries byte lane steering between sequencer and lane unit
// Assumes: Lane unit is purely combinational
// Notes: be is active high here; pins invert it
`timescale 1ns/1ns
`include "pcc_defines.svh"

interface pcc_lane_if;
  logic [1:0] be;
  logic [`PCC_DATA_W-1:0] user_wdata;
  logic [`PCC_DATA_W-1:0] card_wdata;
  logic [`PCC_DATA_W-1:0] card_rdata;
  logic [`PCC_DATA_W-1:0] user_rdata;

  modport ctrl (output be, output user_wdata, output card_rdata,
    input card_wdata, input user_rdata);
  modport lane (input be, input user_wdata, input card_rdata,
    output card_wdata, output user_rdata);
endinterface

// [pcc_sync.sv]
// Purpose: Multi-stage synchroniser for pin inputs
// Assumes: Bits are sampled independently
// Notes: First stage feeds only the next stage
`timescale 1ns/1ns
`include "pcc_defines.svh"

module pcc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_r <= INIT;
      sync_r <= INIT;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule

// [pcc_lane.sv]
// Purpose: Byte lane steering for card data
// Assumes: be already resolved to a legal lane pattern
// Notes: Unused lanes drive and return zero
`timescale 1ns/1ns
`include "pcc_defines.svh"

module pcc_lane
  import pcc_pkg::*;
(
  // Steering
  pcc_lane_if.lane lif
);
  // Keeps only the enabled byte lanes
  function automatic logic [`PCC_DATA_W-1:0] lane_mask(input logic [1:0] be,
    input logic [`PCC_DATA_W-1:0] d);
    lane_mask = {d[`PCC_DATA_W-1:`PCC_BYTE_W] & {`PCC_BYTE_W{be[1]}},
      d[`PCC_BYTE_W-1:0] & {`PCC_BYTE_W{be[0]}}};
  endfunction

  // Low only: D[7:0]; high only: D[15:8]; both: full word
  assign lif.card_wdata = lane_mask(lif.be, lif.user_wdata);
  assign lif.user_rdata = lane_mask(lif.be, lif.card_rdata);
endmodule

// [pcc_host.sv]
// Purpose: Host side cycle sequencer for a 16-bit PC Card slot
// Assumes: One request at a time from on-chip logic on sys_clk
// Notes: All card pins are registered; card inputs pass two flip-flops
`timescale 1ns/1ns
`include "pcc_defines.svh"

// How it works
// - Address goes out multiplexed on 13 pins, qualified by the latch strobe.
// - Three spaces per slot: IO, memory and attribute, each 64M bytes.
// - Space select is high for memory, low for attribute and IO.
// - Memory and attribute cycles use the memory read and write strobes.
// - IO cycles use the dedicated IO read and write strobes.
// - Address is presented first, then one or both byte enables go low.
// - Space select stays inactive during memory cycles.
// - Low enable only: byte on D[7:0], address bit 0 picks even or odd.
// - High enable only: odd byte on D[15:8].
// - Both enables: 16-bit word on D[15:0].
// - Read drops memory or IO read strobe, write the matching write strobe.
// - Card holds wait low to stretch; cycle ends only after its release.
module pcc_host
  import pcc_pkg::*;
#(
  parameter int ALE_CYC = `PCC_ALE_CYC,
  parameter int SETUP_CYC = `PCC_SETUP_CYC,
  parameter int STROBE_CYC = `PCC_STROBE_CYC,
  parameter int RECOVER_CYC = `PCC_RECOVER_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Request from on-chip logic
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire pcc_space_type req_space,
  input wire logic [`PCC_ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_be,
  input wire logic [`PCC_DATA_W-1:0] req_wdata,
  // Answer to on-chip logic
  output logic rsp_valid,
  output logic [`PCC_DATA_W-1:0] rsp_rdata,
  // Card address and control pins
  output logic [`PCC_PIN_ADDR_W-1:0] card_addr,
  output logic addr_latch_strobe,
  output logic space_select_n,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n,
  input wire logic cycle_extend_n,
  // Card data pins
  input wire logic [`PCC_DATA_W-1:0] card_data_in,
  output logic [`PCC_DATA_W-1:0] card_data_out,
  output logic card_data_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Phase length to counter load value, never below one cycle
  function automatic logic [`PCC_CNT_W-1:0] cnt_load(input int cyc);
    int v;
    v = (cyc < 1) ? 0 : cyc - 1;
    cnt_load = v[`PCC_CNT_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pcc_state_type state_r, state_nxt;
  logic [`PCC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`PCC_ADDR_W-1:0] addr_r;
  logic write_r;
  pcc_space_type space_r;
  logic [1:0] be_r;
  logic [`PCC_DATA_W-1:0] wdata_r;

  logic req_ready_r, rsp_valid_r;
  logic [`PCC_DATA_W-1:0] rsp_rdata_r;
  logic [`PCC_PIN_ADDR_W-1:0] card_addr_r, card_addr_nxt;
  logic ale_r, ale_nxt;
  logic space_select_n_r, space_select_n_nxt;
  logic mem_rd_n_r, mem_rd_n_nxt;
  logic mem_wr_n_r, mem_wr_n_nxt;
  logic io_rd_n_r, io_rd_n_nxt;
  logic io_wr_n_r, io_wr_n_nxt;
  logic low_be_n_r, low_be_n_nxt;
  logic high_be_n_r, high_be_n_nxt;
  logic [`PCC_DATA_W-1:0] data_out_r;
  logic data_oe_r, data_oe_nxt;

  logic extend_sync_n;
  logic [`PCC_DATA_W-1:0] data_sync;

  pcc_lane_if lif ();

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Wait resets released so a cycle never stalls on the first edges
  pcc_sync #(
    .WIDTH(1 + `PCC_DATA_W),
    .INIT({1'b1, {`PCC_DATA_W{1'b0}}})
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({cycle_extend_n, card_data_in}),
    .sync_out({extend_sync_n, data_sync})
  );

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  wire accept = (state_r == PCC_ST_IDLE) && req_valid;
  wire [`PCC_ADDR_W-1:0] cur_addr = accept ? req_addr : addr_r;
  wire cur_write = accept ? req_write : write_r;
  wire pcc_space_type cur_space = accept ? req_space : space_r;
  // No lanes asked for is run as a full word
  wire [1:0] req_be_fix = (req_be == `PCC_LANE_NONE) ? `PCC_LANE_BOTH : req_be;
  wire [1:0] cur_be = accept ? req_be_fix : be_r;
  wire cur_io = (cur_space == PCC_SPACE_IO);
  wire cur_mem = (cur_space == PCC_SPACE_MEM);
  wire cnt_zero = (cnt_r == '0);
  wire extend_held = !extend_sync_n;

  // ----------------------------------------------------------------
  // Lane steering
  // ----------------------------------------------------------------
  assign lif.be = cur_be;
  assign lif.user_wdata = accept ? req_wdata : wdata_r;
  assign lif.card_rdata = data_sync;

  pcc_lane u_lane (
    .lif(lif.lane)
  );

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      PCC_ST_IDLE:
      begin
        if (req_valid)
        begin
          state_nxt = PCC_ST_ADDR_HI;
          cnt_nxt = cnt_load(ALE_CYC);
        end
      end
      PCC_ST_ADDR_HI:
      begin
        if (cnt_zero)
        begin
          state_nxt = PCC_ST_ADDR_LO;
          cnt_nxt = cnt_load(SETUP_CYC);
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      PCC_ST_ADDR_LO:
      begin
        if (cnt_zero)
        begin
          state_nxt = PCC_ST_ENABLE;
          cnt_nxt = cnt_load(SETUP_CYC);
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      PCC_ST_ENABLE:
      begin
        if (cnt_zero)
        begin
          state_nxt = PCC_ST_STROBE;
          cnt_nxt = cnt_load(STROBE_CYC);
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      PCC_ST_STROBE:
      begin
        if (!cnt_zero)
          cnt_nxt = cnt_r - 1'b1;
        else if (extend_held)
          state_nxt = PCC_ST_WAIT;
        else
        begin
          state_nxt = PCC_ST_RECOVER;
          cnt_nxt = cnt_load(RECOVER_CYC);
        end
      end
      PCC_ST_WAIT:
      begin
        if (!extend_held)
        begin
          state_nxt = PCC_ST_RECOVER;
          cnt_nxt = cnt_load(RECOVER_CYC);
        end
      end
      PCC_ST_RECOVER:
      begin
        // Only way back to idle is through the quiet recover phase
        if (cnt_zero)
          state_nxt = PCC_ST_IDLE;
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      // Stray codes that match no one-hot state fall back to idle
      default:
        state_nxt = PCC_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin next values
  // ----------------------------------------------------------------
  wire ph_addr_hi = (state_nxt == PCC_ST_ADDR_HI);
  wire ph_active = (state_nxt != PCC_ST_IDLE);
  wire ph_strobe = (state_nxt == PCC_ST_STROBE) || (state_nxt == PCC_ST_WAIT);
  wire ph_enable = ph_strobe || (state_nxt == PCC_ST_ENABLE);
  wire finish = (state_r == PCC_ST_RECOVER) ? 1'b0 :
    ((state_r == PCC_ST_STROBE) || (state_r == PCC_ST_WAIT)) &&
    (state_nxt == PCC_ST_RECOVER);

  // Upper bits first under the latch strobe, then the low bits
  assign card_addr_nxt = ph_addr_hi ?
    cur_addr[`PCC_ADDR_HI_MSB:`PCC_ADDR_HI_LSB] :
    cur_addr[`PCC_ADDR_LO_MSB:0];
  assign ale_nxt = ph_addr_hi;

  // Memory high, attribute and IO low, idle parked high
  assign space_select_n_nxt = !ph_active || cur_mem;

  assign mem_rd_n_nxt = !(ph_strobe && !cur_io && !cur_write);
  assign mem_wr_n_nxt = !(ph_strobe && !cur_io && cur_write);
  assign io_rd_n_nxt = !(ph_strobe && cur_io && !cur_write);
  assign io_wr_n_nxt = !(ph_strobe && cur_io && cur_write);

  assign low_be_n_nxt = !(ph_enable && cur_be[0]);
  assign high_be_n_nxt = !(ph_enable && cur_be[1]);

  // Bus held through recover so write data outlasts the strobe
  assign data_oe_nxt = cur_write && ph_active && !ph_addr_hi &&
    (state_nxt != PCC_ST_ADDR_LO);

  // ----------------------------------------------------------------
  // State and request registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r <= PCC_ST_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      addr_r <= '0;
      write_r <= 1'b0;
      space_r <= PCC_SPACE_MEM;
      be_r <= `PCC_LANE_BOTH;
      wdata_r <= '0;
    end
    else if (accept)
    begin
      addr_r <= req_addr;
      write_r <= req_write;
      space_r <= req_space;
      be_r <= req_be_fix;
      wdata_r <= req_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      card_addr_r <= '0;
      ale_r <= 1'b0;
      space_select_n_r <= 1'b1;
      mem_rd_n_r <= 1'b1;
      mem_wr_n_r <= 1'b1;
      io_rd_n_r <= 1'b1;
      io_wr_n_r <= 1'b1;
      low_be_n_r <= 1'b1;
      high_be_n_r <= 1'b1;
      data_out_r <= '0;
      data_oe_r <= 1'b0;
    end
    else
    begin
      card_addr_r <= card_addr_nxt;
      ale_r <= ale_nxt;
      space_select_n_r <= space_select_n_nxt;
      mem_rd_n_r <= mem_rd_n_nxt;
      mem_wr_n_r <= mem_wr_n_nxt;
      io_rd_n_r <= io_rd_n_nxt;
      io_wr_n_r <= io_wr_n_nxt;
      low_be_n_r <= low_be_n_nxt;
      high_be_n_r <= high_be_n_nxt;
      data_out_r <= lif.card_wdata;
      data_oe_r <= data_oe_nxt;
    end
  end

  // Read data sampled while the strobe is still low, two stages behind
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      req_ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
    end
    else
    begin
      req_ready_r <= (state_nxt == PCC_ST_IDLE);
      rsp_valid_r <= finish;
      if (finish && !write_r)
        rsp_rdata_r <= lif.user_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Port drive
  // ----------------------------------------------------------------
  assign req_ready = req_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign card_addr = card_addr_r;
  assign addr_latch_strobe = ale_r;
  assign space_select_n = space_select_n_r;
  assign mem_read_strobe_n = mem_rd_n_r;
  assign mem_write_strobe_n = mem_wr_n_r;
  assign io_read_strobe_n = io_rd_n_r;
  assign io_write_strobe_n = io_wr_n_r;
  assign low_byte_enable_n = low_be_n_r;
  assign high_byte_enable_n = high_be_n_r;
  assign card_data_out = data_out_r;
  assign card_data_oe = data_oe_r;

endmodule

// [pcc_host_assertions.sv]
// Purpose: Pin sequencing checks for pcc_host
// Assumes: Default strobe length
// Notes: Bound to every pcc_host
`timescale 1ns/1ns
module pcc_host_chk #(
  parameter int ALE_CYC = 2
) (
  // Clock and reset
  input logic sys_clk,
  input logic reset,
  // Host side
  input logic req_ready,
  input logic rsp_valid,
  // Card pins
  input logic addr_latch_strobe,
  input logic space_select_n,
  input logic mem_read_strobe_n,
  input logic mem_write_strobe_n,
  input logic io_read_strobe_n,
  input logic io_write_strobe_n,
  input logic low_byte_enable_n,
  input logic high_byte_enable_n,
  input logic cycle_extend_n,
  input logic card_data_oe
);
  wire [3:0] sn = {mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n};
  wire s_on = sn != 4'hF;
  wire e_on = !(low_byte_enable_n && high_byte_enable_n);
  wire w_on = !(mem_write_strobe_n && io_write_strobe_n);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----
  // Properties
  // ----
  a_one_strobe: assert property ($countones(~sn) <= 1)
    else $error("two strobes low");
  a_io_space: assert property (!(io_read_strobe_n && io_write_strobe_n) |-> !space_select_n)
    else $error("io strobe with space select high");
  a_addr_first: assert property ($rose(e_on) |->
    !addr_latch_strobe && !$past(addr_latch_strobe))
    else $error("enable during address phase");
  a_enable_under: assert property (s_on |-> e_on)
    else $error("strobe without enable");
  a_ale_len: assert property ($rose(addr_latch_strobe) |->
    !e_on && !s_on ##ALE_CYC !addr_latch_strobe)
    else $error("latch strobe phase wrong");
  a_idle_quiet: assert property (req_ready |-> !s_on && !e_on)
    else $error("pins active while idle");
  a_sel_steady: assert property (s_on && $past(s_on) |-> $stable(space_select_n))
    else $error("space select moved in strobe");
  a_wait_holds: assert property (s_on && !$past(cycle_extend_n, 2) &&
    !$past(cycle_extend_n, 3) |=> s_on)
    else $error("strobe ended under wait");
  a_wait_ends: assert property (s_on && $rose(cycle_extend_n) |-> ##[1:5] !s_on)
    else $error("strobe stuck after wait");
  a_rsp_end: assert property ($fell(s_on) |-> rsp_valid ##1 !rsp_valid)
    else $error("answer not at strobe end");
  a_write_drive: assert property (w_on |-> card_data_oe)
    else $error("write without data drive");
  c_io_write: cover property ($fell(io_write_strobe_n));
  c_stretch: cover property (s_on && !cycle_extend_n);
  c_attr_read: cover property (!mem_read_strobe_n && !space_select_n);
endmodule
bind pcc_host pcc_host_chk #(.ALE_CYC(ALE_CYC)) chk (.*);

// [pcc_card_model.sv]
// Purpose: Behavioural card on the slot pins
// Assumes: Bench sets stretch length per cycle
// Notes: Undriven data lanes flip every cycle
`timescale 1ns/1ns
module pcc_card_model (
  // Clock
  input logic sys_clk,
  // From host
  input logic [12:0] card_addr,
  input logic addr_latch_strobe,
  input logic space_select_n,
  input logic mem_read_strobe_n,
  input logic mem_write_strobe_n,
  input logic io_read_strobe_n,
  input logic io_write_strobe_n,
  input logic low_byte_enable_n,
  input logic high_byte_enable_n,
  input logic [15:0] card_data_out,
  input logic card_data_oe,
  // To host
  output logic cycle_extend_n,
  output logic [15:0] card_data_in,
  // Bench side
  input logic [3:0] wait_cyc,
  output logic [25:0] seen_addr,
  output logic [15:0] seen_wdata,
  output logic [1:0] seen_kind,
  output logic seen_sel,
  output logic [1:0] seen_be
);
  logic [12:0] hi = '0;
  logic [15:0] last = '0;
  logic [3:0] wcnt = '0;
  logic on_d = 1'b0;
  wire rd = !(mem_read_strobe_n && io_read_strobe_n);
  wire on = rd || !(mem_write_strobe_n && io_write_strobe_n);
  wire [15:0] m = {{8{!high_byte_enable_n}}, {8{!low_byte_enable_n}}};
  // Read image is the low 16 address bits
  assign card_data_in = rd ? ({hi[2:0], card_addr} & m) | (~last & ~m) : ~last;
  assign cycle_extend_n = wcnt == 4'h0;
  always @(posedge sys_clk)
  begin
    last <= card_data_in;
    on_d <= on;
    if (addr_latch_strobe)
      hi <= card_addr;
    if (on && !on_d)
      wcnt <= wait_cyc;
    else if (wcnt != 4'h0)
      wcnt <= wcnt - 4'h1;
    if (on)
    begin
      seen_addr <= {hi, card_addr};
      seen_kind <= {!(io_read_strobe_n && io_write_strobe_n),
        !(mem_write_strobe_n && io_write_strobe_n)};
      seen_sel <= space_select_n;
      seen_be <= ~{high_byte_enable_n, low_byte_enable_n};
      seen_wdata <= card_data_oe ? card_data_out : ~card_data_out;
    end
  end
endmodule

// [test_pc_card_slot_host_cycles.sv]
// Purpose: Self-checking bench for the card slot sequencer
// Assumes: Default phase lengths
// Notes: Rows run back to back; stretch and reset follow
`timescale 1ns/1ns
module test_pc_card_slot_host_cycles
  import pcc_pkg::*;
;
  typedef struct packed {
    logic w;
    pcc_space_type sp;
    logic [1:0] be;
    logic [25:0] a;
    logic [15:0] d;
    logic sel;
    logic [15:0] x;
  } pcc_row_type;
  // ----
  // Rows: request, then space select and data expected
  // ----
  localparam pcc_row_type ROWS [7] = '{
    '{1'b0, PCC_SPACE_MEM, 2'h3, 26'h2ABCDE4, 16'h0000, 1'b1, 16'hCDE4},
    '{1'b1, PCC_SPACE_MEM, 2'h1, 26'h0000001, 16'h77A5, 1'b1, 16'h00A5},
    '{1'b0, PCC_SPACE_ATTR, 2'h1, 26'h3FFFFFF, 16'h0000, 1'b0, 16'h00FF},
    '{1'b1, PCC_SPACE_ATTR, 2'h2, 26'h1000000, 16'h5A33, 1'b0, 16'h5A00},
    '{1'b0, PCC_SPACE_IO, 2'h2, 26'h0001FFF, 16'h0000, 1'b0, 16'h1F00},
    '{1'b1, PCC_SPACE_IO, 2'h3, 26'h2000000, 16'hBEEF, 1'b0, 16'hBEEF},
    '{1'b0, PCC_SPACE_IO, 2'h0, 26'h0AAAAAA, 16'h0000, 1'b0, 16'hAAAA}
  };
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  pcc_space_type req_space = PCC_SPACE_MEM;
  logic [25:0] req_addr = '0;
  logic [1:0] req_be = '0;
  logic [15:0] req_wdata = '0;
  logic [3:0] wait_cyc = '0;
  wire req_ready, rsp_valid, addr_latch_strobe, space_select_n, mem_read_strobe_n;
  wire mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n, low_byte_enable_n;
  wire high_byte_enable_n, cycle_extend_n, card_data_oe, seen_sel;
  wire [15:0] rsp_rdata, card_data_in, card_data_out, seen_wdata;
  wire [12:0] card_addr;
  wire [25:0] seen_addr;
  wire [1:0] seen_kind, seen_be;
  int fail_count = 0;
  int checks = 0;
  int n;
  always #4 sys_clk = ~sys_clk;
  pcc_host dut (.*);
  pcc_card_model card (.*);
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [25:0] exp, input logic [25:0] seen);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bound();
    if (n >= 60)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic quiet();
    check("idle", 26'h5FC, {req_ready, rsp_valid, mem_read_strobe_n, mem_write_strobe_n,
      io_read_strobe_n, io_write_strobe_n, low_byte_enable_n, high_byte_enable_n,
      space_select_n, addr_latch_strobe, card_data_oe});
    check("rdata", 26'h0, rsp_rdata);
  endtask
  task automatic drive(input pcc_row_type r);
    for (n = 0; n < 60 && req_ready !== 1'b1; n++)
      @(negedge sys_clk);
    bound();
    req_valid = 1'b1;
    req_write = r.w;
    req_space = r.sp;
    req_addr = r.a;
    req_be = r.be;
    req_wdata = r.d;
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  task automatic run(input pcc_row_type r, input logic [3:0] w);
    wait_cyc = w;
    drive(r);
    for (n = 0; n < 60 && rsp_valid !== 1'b1; n++)
      @(negedge sys_clk);
    bound();
    check("addr", r.a, seen_addr);
    check("select", r.sel, seen_sel);
    check("kind", {r.sp == PCC_SPACE_IO, r.w}, seen_kind);
    check("lanes", r.be == 2'h0 ? 2'h3 : r.be, seen_be);
    check("data", r.x, r.w ? seen_wdata : rsp_rdata);
    // Two latch, two setup, four strobe cycles; a stretch adds its length
    check("latency", 26'h1, 26'(n == 8 + w));
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk);
    quiet();
    reset = 1'b0;
    foreach (ROWS[i])
      run(ROWS[i], 4'h0);
    // Stretched cycles, then reset in mid strobe
    run(ROWS[5], 4'h8);
    run(ROWS[0], 4'h6);
    drive(ROWS[2]);
    repeat (5) @(negedge sys_clk);
    reset = 1'b1;
    repeat (5) @(negedge sys_clk);
    quiet();
    reset = 1'b0;
    run(ROWS[2], 4'h0);
    give_verdict();
  end
endmodule
